// ### etcm_defs.svh
`ifndef ETCM_DEFS_SVH
`define ETCM_DEFS_SVH

// word offsets of the configuration bank (16-bit words, byte addresses)
`define ETCM_OFF_EVENT_FLAG       16'h001C
`define ETCM_OFF_CAL_CURRENT      16'h004C
`define ETCM_OFF_CAL_VOLTAGE      16'h0050
`define ETCM_OFF_CAL_ACTIVE       16'h0052
`define ETCM_OFF_CAL_REACTIVE     16'h0056
`define ETCM_OFF_ACCUM_EXP        16'h005A
`define ETCM_OFF_OC_THRESH        16'h005E
`define ETCM_OFF_OP_THRESH        16'h0064
`define ETCM_OFF_HF_THRESH        16'h006A
`define ETCM_OFF_LF_THRESH        16'h006C
`define ETCM_OFF_HT_THRESH        16'h006E
`define ETCM_OFF_LT_THRESH        16'h0070
`define ETCM_OFF_VLOW_THRESH      16'h0072
`define ETCM_OFF_VHIGH_THRESH     16'h0074
`define ETCM_OFF_OC_HOLD          16'h0076
`define ETCM_OFF_OP_HOLD          16'h007A
`define ETCM_OFF_HF_HOLD          16'h007E
`define ETCM_OFF_LF_HOLD          16'h0080
`define ETCM_OFF_HT_HOLD          16'h0082
`define ETCM_OFF_LT_HOLD          16'h0084
`define ETCM_OFF_BANK_LAST        16'h0086
`define ETCM_OFF_EVENT_ENABLE     16'h008A

// reserved words inside the bank: read as zero, writes dropped
`define ETCM_OFF_RSVD_A           16'h005C
`define ETCM_OFF_RSVD_B           16'h0062
`define ETCM_OFF_RSVD_C           16'h0068
`define ETCM_OFF_RSVD_D           16'h0078
`define ETCM_OFF_RSVD_E           16'h007C
`define ETCM_OFF_RSVD_F           16'h0086

// reset values
`define ETCM_RST_WORD             16'h0000
`define ETCM_RST_ENABLE           16'h0000

// event flag bit positions
`define ETCM_BIT_OC               0
`define ETCM_BIT_OP               1
`define ETCM_BIT_HF               2
`define ETCM_BIT_LF               3
`define ETCM_BIT_HT               4
`define ETCM_BIT_LT               5
`define ETCM_BIT_VLOW             6
`define ETCM_BIT_VHIGH            7

// largest usable interval exponent for a 32-bit line counter
`define ETCM_EXP_MAX              5'h1F

`endif

// ### etcm_pkg.sv
package etcm_pkg;

    // number of bank words from the first calibration target to the last reserved word
    localparam int ETCM_BANK_WORDS = 30;
    localparam int ETCM_NUM_EVENTS = 8;

    typedef logic [15:0] etcm_word_t;

    // measured quantities from the calculation engine, one set per computation cycle
    typedef struct packed {
        logic [31:0] current_rms;
        logic [15:0] voltage_rms;
        logic [31:0] active_power;
        logic [15:0] line_freq;
        logic [15:0] temperature;
    } etcm_meas_s;

    // calibration targets handed to the calibration engine
    typedef struct packed {
        logic [31:0] current;
        logic [15:0] voltage;
        logic [31:0] active_power;
        logic [31:0] reactive_power;
    } etcm_cal_s;

    // register access port
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } etcm_req_s;

    // computation cycle sequencer
    typedef enum logic {
        ETCM_ST_ACCUM = 1'b0,
        ETCM_ST_EVAL  = 1'b1
    } etcm_state_e;

endpackage : etcm_pkg

// ### etcm_event_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - computation cycle spans two to the N line cycles
// - writable current and voltage calibration targets
// - writable active and reactive power calibration targets
// - over-current threshold compared, flag recorded when exceeded
// - over-current flag waits for its hold count
// - over-power threshold compared, flag recorded when exceeded
// - over-power flag waits for its hold count
// - over and under frequency thresholds set flags
// - frequency flags wait for their hold counts
// - over and under temperature thresholds set flags
// - temperature flags wait for their hold counts
// - voltage sag and surge thresholds set flags
// - read-only event flag register shows enabled events
// - events evaluated only when enabled
`include "etcm_defs.svh"

module etcm_event_bank (
    // clock, reset and enable
    input  wire logic                clk_sys_i,
    input  wire logic                reset_n_i,
    input  wire logic                ce_i,
    // register access port
    input  wire etcm_pkg::etcm_req_s reg_req_i,
    output logic [15:0]              reg_rdata_o,
    output logic                     reg_rvalid_o,
    // measurement side
    input  wire logic                line_cycle_i,
    input  wire etcm_pkg::etcm_meas_s meas_i,
    // results
    output logic                     comp_cycle_o,
    output logic [15:0]              event_flags_o,
    output etcm_pkg::etcm_cal_s      cal_targets_o
);
    import etcm_pkg::*;

    // bank layout: one flop word per even offset,
    // first target to last spare word, thirty in
    // all, so the index is a shift of the offset
    // and no lookup table sits in the decode
    //
    // 32-bit values span two words written one at
    // a time, so a limit may sit half updated for
    // a clock; evaluation is rare, so no harm
    //
    // every process honours ce_i: a low enable
    // freezes the whole bank in place
    //
    // no interrupt logic here; the flag word and
    // flag port are the only event outputs

    // bank storage, one 16-bit word per index
    etcm_word_t   bank_reg [ETCM_BANK_WORDS];
    etcm_word_t   enable_reg;                   // event enable word
    etcm_word_t   flag_reg;                     // recorded event flags
    logic [31:0]  line_cnt_reg;                 // line cycles within the current interval
    etcm_state_e  state_reg;                    // sequencer state
    etcm_state_e  state_next;
    logic         comp_pulse_reg;               // one clock per finished interval
    logic [15:0]  rdata_reg;                    // read data holding register
    logic         rvalid_reg;                   // read answer strobe

    // hold counters count evaluations, not
    // clocks; they saturate at all ones so a
    // fault that lasts for ages cannot wrap the
    // count to zero and drop a standing flag
    //
    // one counter per event keeps each event
    // easy to follow, at the cost of eight
    // small adders

    // hold counters per event, saturating
    logic [15:0]  hold_cnt_reg [ETCM_NUM_EVENTS];

    // derived comparison inputs
    logic [ETCM_NUM_EVENTS-1:0] breach;         // threshold crossed this cycle
    logic [15:0]                hold_need [ETCM_NUM_EVENTS];
    logic [31:0]                span_last;      // last count of the interval
    logic                       interval_done;

    // address decode helpers
    //
    // offsets are byte offsets of 16-bit words;
    // an odd offset names no word and answers as
    // unmapped, never rounded down, so a host
    // slip shows up as zero data
    //
    // spare words keep real flops only because
    // the index is a shift; both write and read
    // mask them

    // maps a byte offset onto a bank index; valid only for even offsets inside the bank
    function automatic logic bank_hit(input logic [15:0] addr);
        bank_hit = (addr >= `ETCM_OFF_CAL_CURRENT) && (addr <= `ETCM_OFF_BANK_LAST) &&
                   (addr[0] == 1'b0);
    endfunction : bank_hit

    function automatic logic [4:0] bank_idx(input logic [15:0] addr);
        logic [15:0] diff;
        diff     = addr - `ETCM_OFF_CAL_CURRENT;
        bank_idx = diff[5:1];
    endfunction : bank_idx

    // reserved words read zero and drop writes, so software sees no phantom storage
    function automatic logic is_rsvd(input logic [15:0] addr);
        is_rsvd = (addr == `ETCM_OFF_RSVD_A) || (addr == `ETCM_OFF_RSVD_B) ||
                  (addr == `ETCM_OFF_RSVD_C) || (addr == `ETCM_OFF_RSVD_D) ||
                  (addr == `ETCM_OFF_RSVD_E) || (addr == `ETCM_OFF_RSVD_F);
    endfunction : is_rsvd

    // fetches a 16-bit bank word by its byte offset
    function automatic etcm_word_t word_at(input logic [15:0] addr,
                                           input etcm_word_t  mem [ETCM_BANK_WORDS]);
        word_at = mem[bank_idx(addr)];
    endfunction : word_at

    // 32-bit values keep their low half at the lower offset
    function automatic logic [31:0] dword_at(input logic [15:0] addr,
                                             input etcm_word_t  mem [ETCM_BANK_WORDS]);
        dword_at = {mem[bank_idx(addr + 16'h0002)], mem[bank_idx(addr)]};
    endfunction : dword_at

    // register writes
    //
    // a write lands at the edge that takes it,
    // so a read in the same clock sees the old
    // word; the flag word lies outside the bank
    // and can never be written
    //
    // writes get no answer: the host may issue
    // one request every clock

    // register writes into the bank; read-only and reserved words are left alone
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < ETCM_BANK_WORDS; i++) begin
                bank_reg[i] <= `ETCM_RST_WORD;
            end
        end else if (ce_i && reg_req_i.wr && bank_hit(reg_req_i.addr) &&
                     !is_rsvd(reg_req_i.addr)) begin
            bank_reg[bank_idx(reg_req_i.addr)] <= reg_req_i.wdata;
        end
    end

    // event enable word
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            enable_reg <= `ETCM_RST_ENABLE;
        end else if (ce_i && reg_req_i.wr && (reg_req_i.addr == `ETCM_OFF_EVENT_ENABLE)) begin
            enable_reg <= reg_req_i.wdata;
        end
    end

    // register reads
    //
    // read data is registered so port timing
    // does not hang on decode depth; the answer
    // strobe rises one clock after the read and
    // lasts one clock
    //
    // the data word holds until the next read,
    // so a slow host may pick it up late;
    // unmapped offsets answer zero, never stall

    // read mux, answered one clock after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else if (ce_i) begin
            rvalid_reg <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                if (reg_req_i.addr == `ETCM_OFF_EVENT_FLAG) begin
                    rdata_reg <= flag_reg & enable_reg;
                end else if (reg_req_i.addr == `ETCM_OFF_EVENT_ENABLE) begin
                    rdata_reg <= enable_reg;
                end else if (bank_hit(reg_req_i.addr) && !is_rsvd(reg_req_i.addr)) begin
                    rdata_reg <= bank_reg[bank_idx(reg_req_i.addr)];
                end else begin
                    // unmapped, odd or reserved offset
                    rdata_reg <= 16'h0000;
                end
            end
        end
    end

    // computation cycle timing
    //
    // each line pulse advances a counter; the
    // pulse that finds two to the N minus one
    // ends the interval and clears the count
    //
    // N of zero ends an interval on every pulse,
    // the fastest the flags can react; line
    // pulses come from this clock domain

    // last line count of the interval; a huge exponent is clamped to 31, one below the counter width
    always_comb begin
        logic [15:0] expo;
        logic [4:0]  sh;
        expo      = word_at(`ETCM_OFF_ACCUM_EXP, bank_reg);
        sh        = (expo > 16'h001F) ? `ETCM_EXP_MAX : expo[4:0];
        span_last = (32'h0000_0001 << sh) - 32'h0000_0001;
    end

    assign interval_done = line_cycle_i && (line_cnt_reg >= span_last);

    // line cycle counter; an exponent lowered mid-interval to a last count at or below the current count ends the interval on the next line pulse
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            line_cnt_reg <= 32'h0000_0000;
        end else if (ce_i && line_cycle_i) begin
            if (interval_done) begin
                line_cnt_reg <= 32'h0000_0000;
            end else begin
                line_cnt_reg <= line_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // sequencer
    //
    // two states: gather line pulses, then
    // spend one clock judging every limit
    //
    // an interval that ends in the judging
    // clock still restarts the counter but
    // starts no second judgement; pulses that
    // close only come from a broken line input

    // sequencer: accumulate, then one evaluation clock per computation cycle
    always_comb begin
        case (state_reg)
            ETCM_ST_ACCUM: state_next = interval_done ? ETCM_ST_EVAL : ETCM_ST_ACCUM;
            ETCM_ST_EVAL:  state_next = ETCM_ST_ACCUM;
            default:       state_next = ETCM_ST_ACCUM;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_reg      <= ETCM_ST_ACCUM;
            comp_pulse_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg      <= state_next;
            comp_pulse_reg <= (state_reg == ETCM_ST_ACCUM) && interval_done;
        end
    end

    // limit comparisons
    //
    // compares are unsigned and strict, so a
    // value equal to its limit never trips;
    // over limits trip above, sag and under
    // limits trip below
    //
    // the measured set must be steady in the
    // judging clock; it is not latched here

    // threshold comparisons; under and sag limits trip below their threshold
    always_comb begin
        breach                = '0;
        breach[`ETCM_BIT_OC]  = meas_i.current_rms  > dword_at(`ETCM_OFF_OC_THRESH, bank_reg);
        breach[`ETCM_BIT_OP]  = meas_i.active_power > dword_at(`ETCM_OFF_OP_THRESH, bank_reg);
        breach[`ETCM_BIT_HF]  = meas_i.line_freq    > word_at(`ETCM_OFF_HF_THRESH, bank_reg);
        breach[`ETCM_BIT_LF]  = meas_i.line_freq    < word_at(`ETCM_OFF_LF_THRESH, bank_reg);
        breach[`ETCM_BIT_HT]  = meas_i.temperature  > word_at(`ETCM_OFF_HT_THRESH, bank_reg);
        breach[`ETCM_BIT_LT]  = meas_i.temperature  < word_at(`ETCM_OFF_LT_THRESH, bank_reg);
        breach[`ETCM_BIT_VLOW]  = meas_i.voltage_rms < word_at(`ETCM_OFF_VLOW_THRESH, bank_reg);
        breach[`ETCM_BIT_VHIGH] = meas_i.voltage_rms > word_at(`ETCM_OFF_VHIGH_THRESH, bank_reg);
    end

    // hold counts; sag and surge have no hold word and trip on the first breach
    always_comb begin
        hold_need[`ETCM_BIT_OC]    = word_at(`ETCM_OFF_OC_HOLD, bank_reg);
        hold_need[`ETCM_BIT_OP]    = word_at(`ETCM_OFF_OP_HOLD, bank_reg);
        hold_need[`ETCM_BIT_HF]    = word_at(`ETCM_OFF_HF_HOLD, bank_reg);
        hold_need[`ETCM_BIT_LF]    = word_at(`ETCM_OFF_LF_HOLD, bank_reg);
        hold_need[`ETCM_BIT_HT]    = word_at(`ETCM_OFF_HT_HOLD, bank_reg);
        hold_need[`ETCM_BIT_LT]    = word_at(`ETCM_OFF_LT_HOLD, bank_reg);
        hold_need[`ETCM_BIT_VLOW]  = 16'h0000;
        hold_need[`ETCM_BIT_VHIGH] = 16'h0000;
    end

    // hold and flag logic
    //
    // a flag stands only while its streak of
    // breaching evaluations reaches the hold
    // count; one clean evaluation clears both
    //
    // a hold of zero acts as one, so no flag
    // rises without a real breach
    //
    // clearing an enable bit drops the streak,
    // so a re-enabled event starts afresh

    // per event hold counter and flag, updated in the evaluation clock and cleared in any clock while disabled
    for (genvar e = 0; e < ETCM_NUM_EVENTS; e++) begin : g_event
        logic [15:0] cnt_next;      // streak length including this cycle
        logic [15:0] need;          // a hold of zero behaves as one

        assign cnt_next = (hold_cnt_reg[e] == 16'hFFFF) ? 16'hFFFF
                                                        : hold_cnt_reg[e] + 16'h0001;
        assign need     = (hold_need[e] == 16'h0000) ? 16'h0001 : hold_need[e];

        always_ff @(posedge clk_sys_i) begin
            if (!reset_n_i) begin
                hold_cnt_reg[e] <= 16'h0000;
                flag_reg[e]     <= 1'b0;
            end else if (ce_i) begin
                if (!enable_reg[e]) begin
                    // disabled events are not evaluated and lose their streak
                    hold_cnt_reg[e] <= 16'h0000;
                    flag_reg[e]     <= 1'b0;
                end else if (state_reg == ETCM_ST_EVAL) begin
                    if (breach[e]) begin
                        hold_cnt_reg[e] <= cnt_next;
                        flag_reg[e]     <= (cnt_next >= need);
                    end else begin
                        // a broken streak starts over from zero
                        hold_cnt_reg[e] <= 16'h0000;
                        flag_reg[e]     <= 1'b0;
                    end
                end
            end
        end
    end

    // upper flag bits have no event behind them
    for (genvar u = ETCM_NUM_EVENTS; u < 16; u++) begin : g_unused_flag
        assign flag_reg[u] = 1'b0;
    end

    // the flag port masks with the enable word,
    // so a flag vanishes in the clock its enable
    // bit clears, before any evaluation runs
    //

    // outputs
    assign reg_rdata_o   = rdata_reg;
    assign reg_rvalid_o  = rvalid_reg;
    assign comp_cycle_o  = comp_pulse_reg;
    assign event_flags_o = flag_reg & enable_reg;

    // calibration targets straight from the bank
    assign cal_targets_o.current        = dword_at(`ETCM_OFF_CAL_CURRENT, bank_reg);
    assign cal_targets_o.voltage        = word_at(`ETCM_OFF_CAL_VOLTAGE, bank_reg);
    assign cal_targets_o.active_power   = dword_at(`ETCM_OFF_CAL_ACTIVE, bank_reg);
    assign cal_targets_o.reactive_power = dword_at(`ETCM_OFF_CAL_REACTIVE, bank_reg);

endmodule : etcm_event_bank

// ### etcm_event_bank_checker.sv
`timescale 1ns/1ps
// watches the register port, the evaluation strobe and the flag outputs
module etcm_event_bank_checker (
    // clock and reset
    input wire logic                clk_sys_i,
    input wire logic                reset_n_i,
    input wire logic                ce_i,
    // register port
    input wire etcm_pkg::etcm_req_s reg_req_i,
    input wire logic [15:0]         reg_rdata_o,
    input wire logic                reg_rvalid_o,
    // event path
    input wire logic                line_cycle_i,
    input wire logic                comp_cycle_o,
    input wire logic [15:0]         event_flags_o,
    input wire etcm_pkg::etcm_cal_s cal_targets_o
);
    import etcm_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // a taken read is answered one cycle on, and only a read is answered
    property p_rd_ans; ce_i && reg_req_i.rd |=> reg_rvalid_o; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rv_cause; reg_rvalid_o |-> $past(reg_req_i.rd); endproperty
    a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
    // read data must not drift between answers
    property p_rd_hold; !reg_rvalid_o |-> $stable(reg_rdata_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data drifted");
    // calibration targets follow their words exactly
    property p_cal_v;
        ce_i && reg_req_i.wr && reg_req_i.addr == 16'h0050
        |=> cal_targets_o.voltage == $past(reg_req_i.wdata);
    endproperty
    a_cal_v: assert property (p_cal_v) else $error("voltage target lost");
    property p_cal_p;
        ce_i && reg_req_i.wr && reg_req_i.addr == 16'h0052
        |=> cal_targets_o.active_power[15:0] == $past(reg_req_i.wdata);
    endproperty
    a_cal_p: assert property (p_cal_p) else $error("power target lost");
    property p_cal_keep; !(ce_i && reg_req_i.wr) |=> $stable(cal_targets_o); endproperty
    a_cal_keep: assert property (p_cal_keep) else $error("target moved");
    // one evaluation per interval, launched by a line pulse
    property p_comp_gap; comp_cycle_o |=> !comp_cycle_o; endproperty
    a_comp_gap: assert property (p_comp_gap) else $error("double evaluation");
    property p_comp_cause; comp_cycle_o |-> $past(line_cycle_i); endproperty
    a_comp_cause: assert property (p_comp_cause) else $error("stray evaluation");
    // flags move only after an evaluation or an enable write
    property p_flag_when;
        $changed(event_flags_o) |-> $past(comp_cycle_o) || $past(reg_req_i.wr);
    endproperty
    a_flag_when: assert property (p_flag_when) else $error("flags moved");
    property p_flag_top; event_flags_o[15:8] == 8'h00; endproperty
    a_flag_top: assert property (p_flag_top) else $error("unused flag set");
    // main scenarios reached
    c_eval: cover property (comp_cycle_o);
    c_flag: cover property (event_flags_o != 16'h0000);
    c_read: cover property (reg_rvalid_o && reg_rdata_o != 16'h0000);
endmodule : etcm_event_bank_checker

bind etcm_event_bank etcm_event_bank_checker u_chk (
    .clk_sys_i, .reset_n_i, .ce_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o,
    .line_cycle_i, .comp_cycle_o, .event_flags_o, .cal_targets_o
);

// ### etcm_host_model.sv
`timescale 1ns/1ps
// host end of the register port; idle address and data are scrambled on purpose
module etcm_host_model (
    // clock
    input  wire logic         clk_sys_i,
    // register port
    output etcm_pkg::etcm_req_s reg_req_o,
    input  wire logic [15:0]  reg_rdata_i,
    input  wire logic         reg_rvalid_i
);
    import etcm_pkg::*;
    initial reg_req_o = '{16'hFFFF, 1'b0, 1'b0, 16'hFFFF};
    // one write, held across its taking edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_i) #1 reg_req_o = '{a, 1'b1, 1'b0, d};
        @(posedge clk_sys_i) #1 reg_req_o = '{~a, 1'b0, 1'b0, ~d};
    endtask : wr
    // one read; the answer is registered at the taking edge
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk_sys_i) #1 reg_req_o = '{a, 1'b0, 1'b1, 16'h0000};
        @(posedge clk_sys_i) #1 reg_req_o = '{~a, 1'b0, 1'b0, 16'hFFFF};
        ok = reg_rvalid_i;
        d  = reg_rdata_i;
    endtask : rd
endmodule : etcm_host_model

// ### test_event_threshold_and_calibration_targets.sv
`timescale 1ns/1ps
module test_event_threshold_and_calibration_targets;
    import etcm_pkg::*;
    // stimulus
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        line_cycle_i = 1'b0;
    logic        ce_i = 1'b1;
    etcm_meas_s  meas_i;
    etcm_req_s   reg_req;
    // observed
    logic [15:0] reg_rdata, event_flags, rdat;
    logic        reg_rvalid, comp_cycle, rok;
    etcm_cal_s   cal_targets;
    int          bad_count = 0, comparisons = 0, comps = 0;
    // writable words; refused words; limits and holds in flag bit order
    logic [15:0] rw_a [25] = '{16'h004C, 16'h004E, 16'h0050, 16'h0052, 16'h0054,
        16'h0056, 16'h0058, 16'h005A, 16'h005E, 16'h0060, 16'h0064, 16'h0066, 16'h006A,
        16'h006C, 16'h006E, 16'h0070, 16'h0072, 16'h0074, 16'h0076, 16'h007A, 16'h007E,
        16'h0080, 16'h0082, 16'h0084, 16'h008A};
    logic [15:0] rsvd_a [9] = '{16'h005C, 16'h0062, 16'h0068, 16'h0078, 16'h007C,
        16'h0086, 16'h004D, 16'h0090, 16'h001C};
    logic [15:0] thr_a [8] = '{16'h005E, 16'h0064, 16'h006A, 16'h006C, 16'h006E,
        16'h0070, 16'h0072, 16'h0074};
    logic [15:0] hold_a [8] = '{16'h0076, 16'h007A, 16'h007E, 16'h0080, 16'h0082,
        16'h0084, 16'h0000, 16'h0000};
    always #2.5 clk_sys_i = ~clk_sys_i;
    // evaluation strobes seen so far
    always @(posedge clk_sys_i) if (comp_cycle === 1'b1) comps++;
    etcm_event_bank u_dut (
        .clk_sys_i    (clk_sys_i),
        .reset_n_i    (reset_n_i),
        .ce_i         (ce_i),
        .reg_req_i    (reg_req),
        .reg_rdata_o  (reg_rdata),
        .reg_rvalid_o (reg_rvalid),
        .line_cycle_i (line_cycle_i),
        .meas_i       (meas_i),
        .comp_cycle_o (comp_cycle),
        .event_flags_o(event_flags),
        .cal_targets_o(cal_targets)
    );
    etcm_host_model u_host (
        .clk_sys_i   (clk_sys_i),
        .reg_req_o   (reg_req),
        .reg_rdata_i (reg_rdata),
        .reg_rvalid_i(reg_rvalid)
    );
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rchk(logic [15:0] a, logic [15:0] exp);
        u_host.rd(a, rdat, rok);
        chk("read valid", 1, rok);
        chk($sformatf("word %h", a), exp, rdat);
    endtask : rchk
    // equal-to-limit values never trip; i selects the quantity pushed past its limit
    task automatic put(int i, bit br);
        logic [15:0] v;
        v = (i == 3 || i == 5 || i == 6) ? 16'h0080 : 16'h0200;
        meas_i = '{32'h0000_0100, 16'h0100, 32'h0000_0100, 16'h0100, 16'h0100};
        if (br) case (i)
            0: meas_i.current_rms = {16'h0000, v};
            1: meas_i.active_power = {16'h0000, v};
            2, 3: meas_i.line_freq = v;
            4, 5: meas_i.temperature = v;
            default: meas_i.voltage_rms = v;
        endcase
    endtask : put
    // p line pulses, then room for evaluation and flag update
    task automatic pulses(int p, int inc);
        int c0;
        c0 = comps;
        repeat (p) begin
            @(posedge clk_sys_i) #1 line_cycle_i = 1'b1;
            @(posedge clk_sys_i) #1 line_cycle_i = 1'b0;
        end
        repeat (3) @(posedge clk_sys_i);
        #1 chk("evaluations", c0 + inc, comps);
    endtask : pulses
    task automatic t_regs;
        foreach (rw_a[i]) rchk(rw_a[i], 16'h0000);
        foreach (rw_a[i]) u_host.wr(rw_a[i], rw_a[i] ^ 16'h5AC3);
        foreach (rw_a[i]) rchk(rw_a[i], rw_a[i] ^ 16'h5AC3);
        foreach (rsvd_a[i]) u_host.wr(rsvd_a[i], 16'hFFFF);
        foreach (rsvd_a[i]) rchk(rsvd_a[i], 16'h0000);
        chk("cal voltage", 16'h0050 ^ 16'h5AC3, cal_targets.voltage);
        chk("cal current", 32'h004E_004C ^ 32'h5AC3_5AC3, cal_targets.current);
        chk("cal active", 32'h0054_0052 ^ 32'h5AC3_5AC3, cal_targets.active_power);
        chk("cal reactive", 32'h0058_0056 ^ 32'h5AC3_5AC3, cal_targets.reactive_power);
        $display("test t_regs done");
    endtask : t_regs
    task automatic t_interval;
        u_host.wr(16'h005A, 16'h0002);
        pulses(3, 0);
        pulses(1, 1);
        pulses(4, 1);
        // a low enable freezes the line counter, so no interval may end
        ce_i = 1'b0;
        pulses(4, 0);
        ce_i = 1'b1;
        pulses(4, 1);
        $display("test t_interval done");
    endtask : t_interval
    // each event alone: breach, clear, breach, breach; hold of two on all but sag and surge
    task automatic t_events;
        logic [15:0] e, exp_f;
        u_host.wr(16'h005A, 16'h0000);
        u_host.wr(16'h0060, 16'h0000);
        u_host.wr(16'h0066, 16'h0000);
        foreach (thr_a[i]) u_host.wr(thr_a[i], 16'h0100);
        foreach (hold_a[i]) if (hold_a[i] != 16'h0000) u_host.wr(hold_a[i], 16'h0002);
        for (int i = 0; i < 8; i++) begin
            e = 16'h0001 << i;
            u_host.wr(16'h008A, e);
            for (int k = 0; k < 4; k++) begin
                put(i, k != 1);
                pulses(1, 1);
                exp_f = (k == 3 || (k != 1 && hold_a[i] == 16'h0000)) ? e : 16'h0000;
                chk("event flags", exp_f, event_flags);
            end
            rchk(16'h001C, e);
            u_host.wr(16'h008A, 16'h0000);
            chk("flags disabled", 16'h0000, event_flags);
            put(i, 1'b0);
        end
        $display("test t_events done");
    endtask : t_events
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        put(0, 1'b0);
        repeat (16) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        t_regs();
        t_interval();
        t_events();
        tally_and_finish();
    end
    // hang guard, well beyond the roughly five hundred cycles the run needs
    initial begin
        #50000;
        bad_count++;
        tally_and_finish();
    end
endmodule : test_event_threshold_and_calibration_targets
